/* timer16_pkg.sv */
// Constants of the 16-bit timer/counter: register map, fields, reset values and timing
// Overview of operation
// - In external counter mode each rising edge of the external count clock advances the count by one.
// - After external counting is enabled no increment happens until a falling edge has been seen.
// - The low-power crystal oscillator is enabled only while control bit 3 is set.
// - The low-power oscillator keeps running while the rest of the device sleeps.
// - The count runs upward from 0000h to FFFFh and wraps to 0000h on the next increment.
// - Each overflow sets the overflow flag at bit 0 of the first flag register, held until software clears it.
// - The flag is forwarded as an interrupt request only while enable bit 0 of the first enable register is set.
// - With the compare mode field at 1011 a compare match clears the count and starts a conversion if enabled.
// - The trigger clear is honoured in timer and synchronised counter modes, not in asynchronous counter mode.
// - A software write to the count in the same cycle as a trigger clear wins over the clear.
// - In trigger mode the compare value acts as the period: except in asynchronous counter mode, the count clears whenever it equals it.
// - The upper byte of the count is read and written through its own high-byte register.
package timer16_pkg;
  // Register indices; the bus byte address is four times the index
  localparam logic [9:0] MAIN_IRQ_CTRL_IDX = 10'h00b;
  localparam logic [9:0] PERIPH_FLAGS_IDX = 10'h00c;
  localparam logic [9:0] COUNT_LOW_IDX = 10'h00e;
  localparam logic [9:0] COUNT_HIGH_IDX = 10'h00f;
  localparam logic [9:0] COUNTER_CTRL_IDX = 10'h010;
  localparam logic [9:0] PERIPH_ENABLES_IDX = 10'h08c;
  // Control register fields
  localparam int RUN_ENABLE_BIT = 0;
  localparam int SOURCE_SELECT_BIT = 1;
  localparam int SYNC_DISABLE_BIT = 2;
  localparam int OSC_ENABLE_BIT = 3;
  localparam int PRESCALE_LSB = 4;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h3f;
  // Flag and enable fields
  localparam int OVERFLOW_FLAG_BIT = 0;
  localparam int OVERFLOW_IRQ_EN_BIT = 0;
  // Reset values and the top count value
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MAIN_IRQ_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  // Compare unit mode that produces the special event trigger
  localparam logic [3:0] CMP_MODE_TRIGGER = 4'hb;
  // Instruction clock is the core clock over four: last phase of the 2-bit divider
  localparam logic [1:0] QPHASE_LAST = 2'h3;
  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int HTRANS_ACTIVE_BIT = 1;
endpackage : timer16_pkg

/* timer16.sv */
// 16-bit timer/counter with AHB-Lite register slave and an external count clock domain
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module timer16 #(
  parameter int COUNT_W = 16
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic COUNT_CLK,
  input wire logic SLEEP,
  input wire logic [3:0] CMP_MODE,
  input wire logic [15:0] CMP_VALUE,
  input wire logic ADC_ENABLED,
  output logic OSC_ENABLE,
  output logic IRQ_OUT,
  output logic ADC_START
);

  // Gray code helpers for the count crossing
  function automatic logic [COUNT_W-1:0] bin2gray(input logic [COUNT_W-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [COUNT_W-1:0] gray2bin(input logic [COUNT_W-1:0] g);
    logic [COUNT_W-1:0] b;
    b = g;
    for (int i = COUNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction : gray2bin

  // Byte address of a register index
  function automatic logic [11:0] reg_addr(input logic [9:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction : reg_addr

  // Prescaler mask for divide by 1, 2, 4 or 8
  function automatic logic [2:0] prescale_mask(input logic [1:0] sel);
    prescale_mask = 3'((4'h1 << sel) - 4'h1);
  endfunction : prescale_mask

  logic [7:0] ctrl_r;
  logic [7:0] main_irq_r;
  logic flag_r;
  logic irq_en_r;
  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] count_nxt;
  logic dph_wr_r;
  logic dph_rd_r;
  logic [11:0] dph_addr_r;
  logic [1:0] qphase_r;
  logic [2:0] pre_r;
  logic match_prev_r;
  logic [COUNT_W-1:0] last_bin_r;
  logic [COUNT_W-1:0] gray_m_r;
  logic [COUNT_W-1:0] gray_s_r;
  logic ext_mode_r;
  // Link domain
  logic lrst_m_r;
  logic lrst_s_r;
  logic en_m_r;
  logic en_s_r;
  logic fell_r;
  logic [COUNT_W-1:0] link_bin_r;
  logic [COUNT_W-1:0] link_gray_r;

  logic addr_ok;
  logic wr_low;
  logic wr_high;
  logic wr_flags;
  logic qtick;
  logic int_inc;
  logic ext_mode;
  logic async_mode;
  logic trig_ok;
  logic match;
  logic trig;
  logic [COUNT_W-1:0] ext_bin;
  logic [COUNT_W-1:0] ext_delta;
  logic [COUNT_W-1:0] add_val;
  logic [COUNT_W:0] sum;
  logic overflow;
  logic [7:0] rd_byte;

  // Bus decode: a transfer is taken only when the bus is ready
  assign addr_ok = HSEL && HTRANS[timer16_pkg::HTRANS_ACTIVE_BIT] && HREADY;
  assign wr_low = dph_wr_r && (dph_addr_r == reg_addr(timer16_pkg::COUNT_LOW_IDX));
  assign wr_high = dph_wr_r && (dph_addr_r == reg_addr(timer16_pkg::COUNT_HIGH_IDX));
  assign wr_flags = dph_wr_r && (dph_addr_r == reg_addr(timer16_pkg::PERIPH_FLAGS_IDX));

  // Counting modes
  assign ext_mode = ctrl_r[timer16_pkg::RUN_ENABLE_BIT] && ctrl_r[timer16_pkg::SOURCE_SELECT_BIT];
  assign async_mode = ext_mode && ctrl_r[timer16_pkg::SYNC_DISABLE_BIT];
  assign qtick = (qphase_r == timer16_pkg::QPHASE_LAST) && !SLEEP;
  assign int_inc = ctrl_r[timer16_pkg::RUN_ENABLE_BIT] && !ctrl_r[timer16_pkg::SOURCE_SELECT_BIT] && qtick
    && ((pre_r | ~prescale_mask(ctrl_r[timer16_pkg::PRESCALE_LSB +: 2])) == 3'h7);
  assign ext_bin = gray2bin(gray_s_r);
  assign ext_delta = ext_mode ? ext_bin - last_bin_r : '0;
  assign add_val = int_inc ? COUNT_W'(1) : ext_delta;
  assign sum = {1'b0, count_r} + {1'b0, add_val};

  // Special event trigger: fires in every matching cycle unless the previous cycle matched in asynchronous mode; never in asynchronous mode
  assign trig_ok = !async_mode;
  assign match = (CMP_MODE == timer16_pkg::CMP_MODE_TRIGGER) && (count_r == CMP_VALUE);
  assign trig = match && !match_prev_r && trig_ok;
  assign overflow = sum[COUNT_W] && !wr_low && !wr_high && !trig;

  // Count update: bus write first, then trigger clear, then increment
  always_comb begin
    count_nxt = sum[COUNT_W-1:0];
    if (trig) begin
      count_nxt = '0;
    end
    if (wr_low) begin
      count_nxt = {count_r[COUNT_W-1:8], HWDATA[7:0]};
    end
    if (wr_high) begin
      count_nxt = {HWDATA[7:0], count_r[7:0]};
    end
  end

  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    unique case (dph_addr_r)
      reg_addr(timer16_pkg::MAIN_IRQ_CTRL_IDX): rd_byte = main_irq_r;
      reg_addr(timer16_pkg::PERIPH_FLAGS_IDX): rd_byte = {7'h00, flag_r};
      reg_addr(timer16_pkg::COUNT_LOW_IDX): rd_byte = count_r[7:0];
      reg_addr(timer16_pkg::COUNT_HIGH_IDX): rd_byte = count_r[15:8];
      reg_addr(timer16_pkg::COUNTER_CTRL_IDX): rd_byte = ctrl_r;
      reg_addr(timer16_pkg::PERIPH_ENABLES_IDX): rd_byte = {7'h00, irq_en_r};
      default: rd_byte = 8'h00;
    endcase
  end

  // Address phase capture; reads take one wait state so they see the previous write
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      dph_wr_r <= 1'b0;
      dph_rd_r <= 1'b0;
      dph_addr_r <= 12'h000;
    end else begin
      if (HREADYOUT) begin
        dph_wr_r <= addr_ok && HWRITE;
        dph_rd_r <= addr_ok && !HWRITE;
        dph_addr_r <= HADDR;
      end else begin
        dph_rd_r <= 1'b0;
      end
    end
  end

  // Bus answer
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      HREADYOUT <= 1'b1;
      HRDATA <= 32'h0000_0000;
      HRESP <= 1'b0;
    end else begin
      HRESP <= 1'b0;
      if (HREADYOUT && addr_ok && !HWRITE) begin
        HREADYOUT <= 1'b0;
      end else begin
        HREADYOUT <= 1'b1;
      end
      if (dph_rd_r && !HREADYOUT) begin
        HRDATA <= {24'h000000, rd_byte};
      end
    end
  end

  // Control and main interrupt control registers
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      ctrl_r <= timer16_pkg::CTRL_RESET;
      main_irq_r <= timer16_pkg::MAIN_IRQ_RESET;
      irq_en_r <= 1'b0;
    end else if (dph_wr_r) begin
      if (dph_addr_r == reg_addr(timer16_pkg::COUNTER_CTRL_IDX)) begin
        ctrl_r <= HWDATA[7:0] & timer16_pkg::CTRL_WRITE_MASK;
      end
      if (dph_addr_r == reg_addr(timer16_pkg::MAIN_IRQ_CTRL_IDX)) begin
        main_irq_r <= HWDATA[7:0];
      end
      if (dph_addr_r == reg_addr(timer16_pkg::PERIPH_ENABLES_IDX)) begin
        irq_en_r <= HWDATA[timer16_pkg::OVERFLOW_IRQ_EN_BIT];
      end
    end
  end

  // Overflow flag: a new overflow wins over a software clear
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      flag_r <= 1'b0;
    end else if (overflow) begin
      flag_r <= 1'b1;
    end else if (wr_flags) begin
      flag_r <= HWDATA[timer16_pkg::OVERFLOW_FLAG_BIT];
    end
  end

  // Instruction clock divider and prescaler; the divider keeps running in sleep, the prescaler holds because qtick is blocked
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      qphase_r <= 2'h0;
      pre_r <= 3'h0;
    end else begin
      qphase_r <= qphase_r + 2'h1;
      if (wr_low || wr_high || !ctrl_r[timer16_pkg::RUN_ENABLE_BIT]) begin
        pre_r <= 3'h0;
      end else if (qtick) begin
        pre_r <= pre_r + 3'h1;
      end
    end
  end

  // Count register and trigger edge memory
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      count_r <= timer16_pkg::COUNT_RESET;
      match_prev_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      match_prev_r <= match && !trig;
    end
  end

  // Gray count crossing from the link domain; tracks silently outside external mode
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      gray_m_r <= '0;
      gray_s_r <= '0;
      last_bin_r <= '0;
    end else begin
      gray_m_r <= link_gray_r;
      gray_s_r <= gray_m_r;
      last_bin_r <= ext_bin;
    end
  end

  // Outputs: oscillator enable ignores sleep so the crystal keeps time
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      OSC_ENABLE <= 1'b0;
      IRQ_OUT <= 1'b0;
      ADC_START <= 1'b0;
    end else begin
      OSC_ENABLE <= ctrl_r[timer16_pkg::OSC_ENABLE_BIT];
      IRQ_OUT <= flag_r && irq_en_r;
      ADC_START <= trig && ADC_ENABLED;
    end
  end

  // External-mode enable is registered before the crossing so the link synchroniser never sees a glitch
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      ext_mode_r <= 1'b0;
    end else begin
      ext_mode_r <= ext_mode;
    end
  end

  // Link domain: reset and external-mode enable arrive through two flip-flops
  always_ff @(posedge COUNT_CLK) begin
    lrst_m_r <= NRST;
    lrst_s_r <= lrst_m_r;
    en_m_r <= ext_mode_r;
    en_s_r <= en_m_r;
  end

  // Falling edge arms the counter after it is enabled
  always_ff @(negedge COUNT_CLK) begin
    fell_r <= en_s_r && lrst_s_r;
  end

  // Rising edges count only once armed; the count leaves this domain in gray code
  always_ff @(posedge COUNT_CLK) begin
    if (!lrst_s_r) begin
      link_bin_r <= '0;
      link_gray_r <= '0;
    end else if (en_s_r && fell_r) begin
      link_bin_r <= link_bin_r + COUNT_W'(1);
      link_gray_r <= bin2gray(link_bin_r + COUNT_W'(1));
    end
  end

  // Checks in the link domain
  ext_edge_count_a: assert property (@(posedge COUNT_CLK) disable iff (!lrst_s_r)
    en_s_r && fell_r |=> link_bin_r == $past(link_bin_r) + COUNT_W'(1))
    else $error("external edge did not advance the count");
  fall_first_a: assert property (@(posedge COUNT_CLK) disable iff (!lrst_s_r)
    !fell_r |=> link_bin_r == $past(link_bin_r))
    else $error("count advanced before a falling edge");

  // Checks in the core domain
  osc_enable_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    ##1 OSC_ENABLE == $past(ctrl_r[timer16_pkg::OSC_ENABLE_BIT]))
    else $error("oscillator enable does not follow control bit");
  osc_sleep_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (SLEEP && ctrl_r[timer16_pkg::OSC_ENABLE_BIT]) [*2] |-> OSC_ENABLE)
    else $error("oscillator stopped in sleep");
  count_wrap_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    count_r == timer16_pkg::COUNT_MAX && int_inc && !wr_low && !wr_high && !trig
    |=> count_r == timer16_pkg::COUNT_RESET && flag_r)
    else $error("wrap from FFFF did not give zero and flag");
  flag_hold_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    flag_r && !wr_flags |=> flag_r)
    else $error("overflow flag lost without a clear");
  irq_gate_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    ##1 IRQ_OUT == ($past(flag_r) && $past(irq_en_r)))
    else $error("interrupt request not gated by enable");
  trig_clear_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    trig && !wr_low && !wr_high |=> count_r == '0 && ADC_START == $past(ADC_ENABLED))
    else $error("trigger did not clear count or start conversion");
  async_trig_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    async_mode && !wr_low && !wr_high |=> count_r == $past(sum[COUNT_W-1:0]))
    else $error("trigger honoured in asynchronous mode");
  write_wins_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    trig && wr_low |=> count_r[7:0] == $past(HWDATA[7:0]))
    else $error("trigger overrode a count write");
  high_read_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    dph_rd_r && !HREADYOUT && dph_addr_r == reg_addr(timer16_pkg::COUNT_HIGH_IDX)
    |=> HREADYOUT && HRDATA[7:0] == $past(count_r[15:8]))
    else $error("high byte read mismatch");
  int_phase_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    int_inc |-> qphase_r == timer16_pkg::QPHASE_LAST && !SLEEP)
    else $error("internal increment off the instruction clock");
  flag_set_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    overflow |=> flag_r)
    else $error("overflow did not set the flag");
  irq_mask_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !irq_en_r |=> !IRQ_OUT)
    else $error("interrupt request while masked");
  adc_gate_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !ADC_ENABLED || !trig |=> !ADC_START)
    else $error("conversion start without trigger or converter");
  low_write_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    wr_low |=> count_r[7:0] == $past(HWDATA[7:0]) && count_r[15:8] == $past(count_r[15:8]))
    else $error("low byte write lost");
  period_clear_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    CMP_MODE == timer16_pkg::CMP_MODE_TRIGGER && count_r == CMP_VALUE && !match_prev_r && !async_mode
    && !wr_low && !wr_high |=> count_r == '0)
    else $error("count not cleared at the compare period");
  high_write_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    wr_high |=> count_r[15:8] == $past(HWDATA[7:0]))
    else $error("high byte write lost");
  ctrl_mask_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    ctrl_r[7:6] == 2'h0)
    else $error("unimplemented control bits set");
  int_rate_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    int_inc |=> !int_inc [*3])
    else $error("internal increments closer than four core clocks");
  sleep_hold_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    SLEEP && !ctrl_r[timer16_pkg::SOURCE_SELECT_BIT] && !wr_low && !wr_high && !trig |=> count_r == $past(count_r))
    else $error("internal count advanced in sleep");

  // Main scenarios
  overflow_c: cover property (@(posedge REF_CLK) disable iff (!NRST) overflow);
  trigger_c: cover property (@(posedge REF_CLK) disable iff (!NRST) trig ##1 ADC_START);
  ext_count_c: cover property (@(posedge REF_CLK) disable iff (!NRST) ext_mode && ext_delta != '0);
  write_trig_c: cover property (@(posedge REF_CLK) disable iff (!NRST) trig && wr_low);
  async_match_c: cover property (@(posedge REF_CLK) disable iff (!NRST) async_mode && match);

endmodule : timer16

/* count_source.sv */
// Far-side model: external count clock that only toggles inside bursts
`timescale 1ns/10ps
module count_source (
  output logic COUNT_CLK
);
  // Idle low, so once counting is enabled the first counted rising edge follows a falling edge
  initial COUNT_CLK = 1'b0;

  // Burst of n full pulses at a 6 ns period, offset so it never lines up with the core clock
  task automatic burst(input int n);
    #1.3;
    repeat (n) begin
      #3 COUNT_CLK = 1'b1; // Rising edge is the count event
      #3 COUNT_CLK = 1'b0;
    end
  endtask : burst
endmodule : count_source

/* sixteen_bit_timer_counter_tb_top.sv */
// Self-checking testbench of the 16-bit timer/counter
`timescale 1ns/10ps
module sixteen_bit_timer_counter_tb_top;
  localparam logic [11:0] A_IRQ = {timer16_pkg::MAIN_IRQ_CTRL_IDX, 2'h0};
  localparam logic [11:0] A_FLG = {timer16_pkg::PERIPH_FLAGS_IDX, 2'h0};
  localparam logic [11:0] A_LO = {timer16_pkg::COUNT_LOW_IDX, 2'h0};
  localparam logic [11:0] A_HI = {timer16_pkg::COUNT_HIGH_IDX, 2'h0};
  localparam logic [11:0] A_CTL = {timer16_pkg::COUNTER_CTRL_IDX, 2'h0};
  localparam logic [11:0] A_EN = {timer16_pkg::PERIPH_ENABLES_IDX, 2'h0};
  logic REF_CLK = 1'b0;
  logic NRST = 1'b0;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic SLEEP = 1'b0;
  logic ADC_ENABLED = 1'b0;
  logic data_ph = 1'b0;
  logic [11:0] HADDR = 12'h000;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h00000000;
  logic [3:0] CMP_MODE = 4'h0;
  logic [15:0] CMP_VALUE = 16'h0000;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, COUNT_CLK, OSC_ENABLE, IRQ_OUT, ADC_START;
  logic [15:0] rv, cv;
  logic [31:0] lo_q[$];
  logic [31:0] hi_q[$];
  int n_fail = 0;
  int checked = 0;
  int n_adc = 0;
  int n;

  always #20 REF_CLK = ~REF_CLK;

  count_source SRC (.COUNT_CLK(COUNT_CLK));

  // Single slave, so its ready output is the bus ready
  timer16 DUT (.REF_CLK(REF_CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .COUNT_CLK(COUNT_CLK), .SLEEP(SLEEP), .CMP_MODE(CMP_MODE), .CMP_VALUE(CMP_VALUE),
    .ADC_ENABLED(ADC_ENABLED), .OSC_ENABLE(OSC_ENABLE), .IRQ_OUT(IRQ_OUT), .ADC_START(ADC_START));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (n_fail == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // One AHB single transfer; address and data phases each held until ready is sampled high
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= a;
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    data_ph <= ~w;
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
    data_ph <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h000000, d});
  endtask : wr

  // The expected window goes on the queue before the read is issued
  task automatic rd(input logic [11:0] a, input logic [31:0] lo, input logic [31:0] hi);
    lo_q.push_back(lo);
    hi_q.push_back(hi);
    bus(1'b0, a, 32'h00000000);
  endtask : rd

  // Watches the outputs: a finished read data phase takes the oldest note; conversion starts are counted
  always @(posedge REF_CLK) begin
    if (data_ph === 1'b1 && HREADYOUT === 1'b1) begin
      check({31'h0, HRESP}, 32'h0);
      if (lo_q[0] === hi_q[0]) check(HRDATA, lo_q[0]);
      else check({31'h0, HRDATA >= lo_q[0] && HRDATA <= hi_q[0]}, 32'h1);
      void'(lo_q.pop_front());
      void'(hi_q.pop_front());
    end
    if (ADC_START === 1'b1) n_adc++;
  end

  // Watchdog sized well above the fewer than two thousand cycles the sequence needs
  initial begin
    #2000000;
    n_fail++;
    finish_test();
  end

  // Main sequence; the link domain needs edges during reset to take the reset itself
  initial begin
    void'($urandom(32'he1289358));
    SRC.burst(8);
    repeat (16) @(posedge REF_CLK);
    NRST <= 1'b1;
    rd(A_CTL, 0, 0);
    rd(A_FLG, 0, 0);
    rd(A_EN, 0, 0);
    rd(A_LO, 0, 0);
    rd(A_HI, 0, 0);
    rd(A_IRQ, 0, 0);
    wr(12'h100, 8'h5a);
    rd(12'h100, 0, 0);
    wr(A_CTL, 8'hff);
    rd(A_CTL, 32'h3f, 32'h3f);
    SLEEP <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    check({31'h0, OSC_ENABLE}, 32'h1);
    wr(A_CTL, 8'h00);
    SLEEP <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    check({31'h0, OSC_ENABLE}, 32'h0);
    rv = 16'($urandom);
    wr(A_LO, rv[7:0]);
    wr(A_HI, rv[15:8]);
    rd(A_LO, {24'h0, rv[7:0]}, {24'h0, rv[7:0]});
    rd(A_HI, {24'h0, rv[15:8]}, {24'h0, rv[15:8]});
    // Roll over from the top value with the interrupt first masked, then unmasked
    wr(A_LO, 8'hff);
    wr(A_HI, 8'hff);
    wr(A_CTL, 8'h01);
    repeat (20) @(posedge REF_CLK);
    wr(A_CTL, 8'h00);
    rd(A_HI, 0, 0);
    rd(A_FLG, 1, 1);
    check({31'h0, IRQ_OUT}, 32'h0);
    wr(A_EN, 8'h01);
    repeat (3) @(posedge REF_CLK);
    check({31'h0, IRQ_OUT}, 32'h1);
    repeat (40) @(posedge REF_CLK);
    rd(A_FLG, 1, 1);
    wr(A_FLG, 8'h00);
    rd(A_FLG, 0, 0);
    check({31'h0, IRQ_OUT}, 32'h0);
    wr(A_EN, 8'h00);
    // Each prescale runs 256 cycles; the divider phase leaves one count of slack
    for (int p = 0; p < 4; p++) begin
      wr(A_LO, 8'h00);
      wr(A_HI, 8'h00);
      wr(A_CTL, 8'(8'h01 | (p << 4)));
      repeat (253) @(posedge REF_CLK);
      wr(A_CTL, 8'h00);
      rd(A_LO, 32'((64 >> p) - 1), 32'((64 >> p) + 1));
    end
    // Special event trigger: compare value is the period and starts conversions
    cv = 16'd8 + 16'($urandom % 8);
    CMP_VALUE <= cv;
    CMP_MODE <= timer16_pkg::CMP_MODE_TRIGGER;
    ADC_ENABLED <= 1'b1;
    wr(A_LO, 8'h00);
    n_adc = 0;
    wr(A_CTL, 8'h01);
    repeat (200) @(posedge REF_CLK);
    wr(A_CTL, 8'h00);
    check({31'h0, n_adc >= 2}, 32'h1);
    rd(A_HI, 0, 0);
    rd(A_LO, 0, {16'h0, cv});
    rd(A_FLG, 0, 0);
    ADC_ENABLED <= 1'b0;
    n_adc = 0;
    wr(A_CTL, 8'h01);
    repeat (100) @(posedge REF_CLK);
    wr(A_CTL, 8'h00);
    check(32'(n_adc), 32'h0);
    // A written match clears the count in synchronised counter mode, not in asynchronous mode
    wr(A_CTL, 8'h07);
    wr(A_LO, 8'h00);
    wr(A_LO, cv[7:0]);
    repeat (8) @(posedge REF_CLK);
    rd(A_LO, {16'h0, cv}, {16'h0, cv});
    wr(A_CTL, 8'h03);
    wr(A_LO, 8'h00);
    wr(A_LO, cv[7:0]);
    repeat (8) @(posedge REF_CLK);
    rd(A_LO, 0, 0);
    // A count write in the very cycle of a trigger clear keeps the written value
    CMP_VALUE <= 16'h00ff;
    fork
      wr(A_LO, 8'h55);
      begin
        repeat (2) @(posedge REF_CLK);
        CMP_VALUE <= 16'h0000;
      end
    join
    rd(A_LO, 32'h55, 32'h55);
    // External counting: warm-up burst passes the enable and falling edge, then an exact burst
    CMP_MODE <= 4'h0;
    SRC.burst(4);
    repeat (12) @(posedge REF_CLK);
    wr(A_LO, 8'h00);
    n = 5 + int'($urandom % 8);
    SRC.burst(n);
    repeat (12) @(posedge REF_CLK);
    rd(A_LO, 32'(n), 32'(n));
    finish_test();
  end
endmodule : sixteen_bit_timer_counter_tb_top
